/* rtl/sepc_pkg.sv */
// Shared constants and types for the serial EEPROM pause and power-up control.
// Assumes a single core clock that samples every serial pin.
package sepc_pkg;

    localparam int unsigned CORE_CLK_MHZ = 50;
    localparam int unsigned WR_CYCLE_US  = 5;

    localparam logic [7:0] OP_WR_EN   = 8'h06;
    localparam logic [7:0] OP_WR_DIS  = 8'h04;
    localparam logic [7:0] OP_STAT_RD = 8'h05;
    localparam logic [7:0] OP_STAT_WR = 8'h01;
    localparam logic [7:0] OP_READ    = 8'h03;
    localparam logic [7:0] OP_WRITE   = 8'h02;

    localparam int unsigned STAT_BUSY_BIT = 0;
    localparam int unsigned STAT_WEL_BIT  = 1;
    localparam logic [7:0]  STAT_WR_MASK  = 8'hDC;
    localparam logic [7:0]  STAT_RST      = 8'h00;

    localparam logic [2:0] BIT_FIRST       = 3'h0;
    localparam logic [2:0] BYTE_MSB        = 3'h7;
    localparam logic [2:0] BYTES_CMD       = 3'h1;
    localparam logic [2:0] BYTES_WRSR      = 3'h2;
    localparam logic [2:0] BYTES_WRITE_MIN = 3'h4;
    localparam logic [2:0] BYTES_SAT       = 3'h7;

    // Synchroniser bit order is {cs_n, hold_n, sck, si}; idle pins are deselected.
    localparam int unsigned SYNC_W   = 4;
    localparam logic [3:0]  SYNC_RST = 4'hC;

    typedef enum logic [2:0] {
        PH_OPCODE,
        PH_WR_EN,
        PH_WR_DIS,
        PH_STAT_OUT,
        PH_READ_OUT,
        PH_WRITE,
        PH_STAT_WR,
        PH_IGNORE
    } sepc_phase_t;

endpackage

/* rtl/sepc_link_if.sv */
// Carries the synchronised serial pins and clock edges to the control logic.
// Assumes every signal is already in the core clock domain.
interface sepc_link_if;
    logic sck_rise;
    logic sck_fall;
    logic cs_n;
    logic hold_n;
    logic si;

    modport src (output sck_rise, output sck_fall, output cs_n, output hold_n, output si);
    modport dst (input sck_rise, input sck_fall, input cs_n, input hold_n, input si);
endinterface

/* rtl/sepc_in_sync.sv */
// Two-stage synchronisers for the serial pins and serial clock edge detection.
// Assumes pins are asynchronous to i_core_clk and the serial clock is much slower.
module sepc_in_sync
    import sepc_pkg::*;
(
    input  wire logic  i_core_clk,
    input  wire logic  i_rst,
    input  wire logic  i_sck,
    input  wire logic  i_cs_n,
    input  wire logic  i_si,
    input  wire logic  i_hold_n,
    sepc_link_if.src   link
);
    logic [SYNC_W-1:0] raw;
    logic [SYNC_W-1:0] meta_q;
    logic [SYNC_W-1:0] sync_q;
    logic              sck_prev_q;

    assign raw = {i_cs_n, i_hold_n, i_sck, i_si};

    for (genvar g = 0; g < SYNC_W; g++) begin : g_sync
        always_ff @(posedge i_core_clk or posedge i_rst) begin
            if (i_rst) begin
                meta_q[g] <= SYNC_RST[g];
                sync_q[g] <= SYNC_RST[g];
            end else begin
                meta_q[g] <= raw[g];
                sync_q[g] <= meta_q[g];
            end
        end
    end

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            sck_prev_q <= 1'b0;
        end else begin
            sck_prev_q <= sync_q[1];
        end
    end

    assign link.cs_n     = sync_q[3];
    assign link.hold_n   = sync_q[2];
    assign link.si       = sync_q[0];
    assign link.sck_rise = sync_q[1] & ~sck_prev_q;
    assign link.sck_fall = ~sync_q[1] & sck_prev_q;

endmodule // sepc_in_sync

/* rtl/sepc_top.sv */
// Serial EEPROM command front end: pause handling, power-up state, write cycle gating.
// Assumes a mode 0 host on the serial pins; the memory array sits outside this block.
//
// Contract
// - Paused: output released, input ignored.
// - Power reset clears all state into standby.
// - Latch clear after power-up; writes refused.
// - Completed write cycle clears the write latch.
// - Write cycle starts only on select release.
// - Array accesses ignored while write cycle runs.
// - Unknown opcode: no action, output stays released.
// - During write cycle only status read accepted.
// - Write enable command sets latch and bit.
// - Busy status bit high while cycle runs.
module sepc_top
    import sepc_pkg::*;
#(
    parameter int unsigned WR_CYCLE_CYC = WR_CYCLE_US * CORE_CLK_MHZ
) (
    input  wire logic       i_core_clk,
    input  wire logic       i_rst,
    input  wire logic       i_sck,
    input  wire logic       i_cs_n,
    input  wire logic       i_si,
    input  wire logic       i_hold_n,
    input  wire logic [7:0] i_rd_data,
    output logic            o_so,
    output logic            o_so_oe,
    output logic            o_write_start,
    output logic            o_wel,
    output logic            o_busy
);
    sepc_link_if link ();

    sepc_in_sync u_sync (
        .i_core_clk (i_core_clk),
        .i_rst      (i_rst),
        .i_sck      (i_sck),
        .i_cs_n     (i_cs_n),
        .i_si       (i_si),
        .i_hold_n   (i_hold_n),
        .link       (link)
    );

    sepc_phase_t phase_q;
    logic [2:0]  bit_q;
    logic [2:0]  bytes_q;
    logic [7:0]  shin_q;
    logic [2:0]  out_cnt_q;
    logic        so_q;
    logic        drive_q;
    logic        cs_prev_q;
    logic        wel_q;
    logic        busy_q;
    logic [31:0] wc_cnt_q;
    logic [7:0]  stat_q;
    logic        start_q;

    // Command decode; writes need the latch and a busy device takes status reads only.
    function automatic sepc_phase_t decode_op(input logic [7:0] op, input logic busy,
                                              input logic write_enable_latch);
        sepc_phase_t ph;
        ph = PH_IGNORE;
        if (!busy || op == OP_STAT_RD) begin
            unique case (op)
                OP_WR_EN:   ph = PH_WR_EN;
                OP_WR_DIS:  ph = PH_WR_DIS;
                OP_STAT_RD: ph = PH_STAT_OUT;
                OP_READ:    ph = PH_READ_OUT;
                OP_WRITE:   ph = write_enable_latch ? PH_WRITE : PH_IGNORE;
                OP_STAT_WR: ph = write_enable_latch ? PH_STAT_WR : PH_IGNORE;
                default:    ph = PH_IGNORE;
            endcase
        end
        return ph;
    endfunction

    wire       sel       = ~link.cs_n;
    wire       paused    = sel & ~link.hold_n;
    wire       act_rise  = sel & link.hold_n & link.sck_rise;
    wire       act_fall  = sel & link.hold_n & link.sck_fall;
    wire       cs_rise   = link.cs_n & ~cs_prev_q;
    wire       byte_done = act_rise & (bit_q == BYTE_MSB);
    wire [7:0] opcode    = {shin_q[6:0], link.si};
    wire       aligned   = (bit_q == BIT_FIRST);
    wire       out_phase = (phase_q == PH_STAT_OUT) | (phase_q == PH_READ_OUT);
    wire       wc_done   = busy_q & (wc_cnt_q == WR_CYCLE_CYC - 32'h1);

    wire arm_write = (phase_q == PH_WRITE) & aligned & (bytes_q >= BYTES_WRITE_MIN);
    wire arm_wrsr  = (phase_q == PH_STAT_WR) & aligned & (bytes_q == BYTES_WRSR);
    wire write_enable_command_ok   = (phase_q == PH_WR_EN) & aligned & (bytes_q == BYTES_CMD);
    wire wrdi_ok   = (phase_q == PH_WR_DIS) & aligned & (bytes_q == BYTES_CMD);
    wire start_wc  = cs_rise & (arm_write | arm_wrsr);

    logic [7:0] stat_byte;
    always_comb begin
        stat_byte = stat_q;
        stat_byte[STAT_WEL_BIT]  = wel_q;
        stat_byte[STAT_BUSY_BIT] = busy_q;
    end

    wire [7:0] out_byte = (phase_q == PH_STAT_OUT) ? stat_byte : i_rd_data;

    // Input side: only advances on active clock edges, so a pause holds everything.
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            phase_q <= PH_OPCODE;
            bit_q   <= BIT_FIRST;
            bytes_q <= BIT_FIRST;
            shin_q  <= STAT_RST;
        end else if (!sel) begin
            phase_q <= PH_OPCODE;
            bit_q   <= BIT_FIRST;
            bytes_q <= BIT_FIRST;
        end else if (act_rise) begin
            shin_q <= opcode;
            bit_q  <= bit_q + 3'h1;
            if (byte_done && bytes_q != BYTES_SAT) begin
                bytes_q <= bytes_q + 3'h1;
            end
            if (byte_done && phase_q == PH_OPCODE) begin
                phase_q <= decode_op(opcode, busy_q, wel_q);
            end
        end
    end

    // Output side: the first bit leaves on the falling edge after the opcode.
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            out_cnt_q <= BIT_FIRST;
            so_q      <= 1'b0;
            drive_q   <= 1'b0;
        end else if (!sel) begin
            out_cnt_q <= BIT_FIRST;
            drive_q   <= 1'b0;
        end else if (act_fall && out_phase) begin
            so_q      <= out_byte[BYTE_MSB - out_cnt_q];
            out_cnt_q <= out_cnt_q + 3'h1;
            drive_q   <= 1'b1;
        end
    end

    // The internal cycle and the latch live apart from selection state.
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            cs_prev_q <= 1'b1;
            wel_q     <= 1'b0;
            busy_q    <= 1'b0;
            wc_cnt_q  <= 32'h0;
            stat_q    <= STAT_RST;
            start_q   <= 1'b0;
        end else begin
            cs_prev_q <= link.cs_n;
            start_q   <= start_wc;
            if (start_wc) begin
                busy_q   <= 1'b1;
                wc_cnt_q <= 32'h0;
                if (arm_wrsr) begin
                    stat_q <= shin_q & STAT_WR_MASK;
                end
            end else if (wc_done) begin
                busy_q <= 1'b0;
            end else if (busy_q) begin
                wc_cnt_q <= wc_cnt_q + 32'h1;
            end
            if (wc_done || (cs_rise && wrdi_ok)) begin
                wel_q <= 1'b0;
            end else if (cs_rise && write_enable_command_ok) begin
                wel_q <= 1'b1;
            end
        end
    end

    // A pause releases the pin at once instead of waiting for a clock edge.
    assign o_so          = so_q;
    assign o_so_oe       = drive_q & sel & link.hold_n & out_phase;
    assign o_write_start = start_q;
    assign o_wel         = wel_q;
    assign o_busy        = busy_q;

    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (i_rst);

    pause_hiz_a: assert property (paused |-> !o_so_oe)
        else $error("Output driven during pause.");
    pause_freeze_a: assert property (paused |=> $stable(bit_q) && $stable(shin_q)
                                     && $stable(out_cnt_q) && $stable(phase_q))
        else $error("State moved during pause.");
    por_clear_a: assert property (disable iff (1'b0) i_rst |=> !wel_q && !busy_q)
        else $error("Power reset left state set.");
    write_needs_wel_a: assert property (start_wc |-> wel_q)
        else $error("Write cycle without latch.");
    done_clears_wel_a: assert property (wc_done |=> !wel_q && !busy_q)
        else $error("Latch kept after write cycle.");
    start_on_cs_a: assert property ($rose(busy_q) |-> $past(cs_rise) && o_write_start)
        else $error("Write cycle began without select release.");
    busy_gate_a: assert property (busy_q && byte_done && phase_q == PH_OPCODE
                                  && opcode != OP_STAT_RD |=> phase_q == PH_IGNORE)
        else $error("Command accepted while busy.");
    ignore_hiz_a: assert property (phase_q == PH_IGNORE |-> !o_so_oe)
        else $error("Output driven after bad opcode.");
    write_enable_command_sets_a: assert property (cs_rise && write_enable_command_ok |=> wel_q && stat_byte[STAT_WEL_BIT])
        else $error("Write enable did not set latch.");
    busy_bit_a: assert property (start_wc |=> stat_byte[STAT_BUSY_BIT] [*8])
        else $error("Busy bit low during write cycle.");
    wel_rise_a: assert property ($rose(wel_q) |-> $past(cs_rise && write_enable_command_ok))
        else $error("Latch set without write enable command.");
    start_pulse_a: assert property (o_write_start |=> !o_write_start)
        else $error("Write start pulse longer than one cycle.");
    ignore_keep_a: assert property (phase_q == PH_IGNORE && sel |=> phase_q == PH_IGNORE)
        else $error("Ignored selection resumed decoding.");

    pause_seen_c: cover property (paused ##1 !paused && sel);
    stat_poll_c: cover property (busy_q && act_fall && phase_q == PH_STAT_OUT);
    wc_run_c: cover property (start_wc ##[1:1000] wc_done);
    bad_op_c: cover property (phase_q == PH_IGNORE && !busy_q);

endmodule // sepc_top

/* verification/sepc_host_model.sv */
// Behavioural mode 0 host controller that drives the serial pins of the EEPROM front end.
// Assumes the core clock is shared and every pin moves just after its rising edge.
module sepc_host_model (
    input  wire logic i_core_clk,
    input  wire logic i_so,
    input  wire logic i_so_oe,
    output logic      o_sck,
    output logic      o_cs_n,
    output logic      o_si,
    output logic      o_hold_n
);
    timeunit 1ns;
    timeprecision 1ps;

    logic oe_seen;
    logic so_line;

    // No pull resistor on the line, so a released output reads as the inverse of the last bit.
    assign so_line = i_so_oe ? i_so : ~i_so;

    initial begin
        o_sck    = 1'b0;
        o_cs_n   = 1'b1;
        o_si     = 1'b0;
        o_hold_n = 1'b1;
        oe_seen  = 1'b0;
    end

    // One bit is 8 core cycles, so the serial clock runs at 160 ns and idles low.
    task automatic shift(input int n, input logic [7:0] tx, output logic [7:0] rx);
        rx = 8'h00;
        for (int i = n - 1; i >= 0; i--) begin
            @(posedge i_core_clk);
            o_si <= tx[i];
            repeat (4) @(posedge i_core_clk);
            o_sck <= 1'b1;
            repeat (2) @(posedge i_core_clk);
            @(negedge i_core_clk);
            rx = {rx[6:0], so_line};
            oe_seen = oe_seen | i_so_oe;
            @(posedge i_core_clk);
            o_sck <= 1'b0;
        end
    endtask

    task automatic select();
        @(posedge i_core_clk);
        o_cs_n <= 1'b0;
        oe_seen = 1'b0;
        repeat (4) @(posedge i_core_clk);
    endtask

    task automatic deselect();
        repeat (4) @(posedge i_core_clk);
        o_cs_n <= 1'b1;
        repeat (10) @(posedge i_core_clk);
        @(negedge i_core_clk);
    endtask

    // The clock and data keep moving during the pause, so a leaky freeze shows up.
    task automatic pause(input int cyc, output logic oe_paused);
        oe_paused = 1'b0;
        @(posedge i_core_clk);
        o_hold_n <= 1'b0;
        for (int i = 0; i < cyc; i++) begin
            @(posedge i_core_clk);
            o_si  <= ~o_si;
            o_sck <= i[2];
            if (i > 4) oe_paused = oe_paused | i_so_oe;
        end
        @(posedge i_core_clk);
        o_sck <= 1'b0;
        @(posedge i_core_clk);
        o_hold_n <= 1'b1;
    endtask
endmodule // sepc_host_model

/* verification/tb_top.sv */
// Self-checking bench for the EEPROM front end, driven through the host model.
// Assumes a write cycle of WR_CYC core cycles, four times the 250-cycle default.
module tb_top
    import sepc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int unsigned WR_CYC = 1000;

    logic       i_core_clk = 1'b0;
    logic       i_rst      = 1'b1;
    logic [7:0] i_rd_data  = 8'hA5;
    logic       sck, cs_n, si, hold_n, so, so_oe, wstart, write_enable_latch, busy;
    logic [7:0] rx, ry;
    logic       f1, f2;
    int         n_fail = 0, checks_done = 0, n_start = 0;

    always #10 i_core_clk = ~i_core_clk;
    always @(posedge i_core_clk) if (wstart === 1'b1) n_start++;

    sepc_top #(.WR_CYCLE_CYC(WR_CYC)) u_dut (.i_core_clk(i_core_clk), .i_rst(i_rst),
        .i_sck(sck), .i_cs_n(cs_n), .i_si(si), .i_hold_n(hold_n), .i_rd_data(i_rd_data),
        .o_so(so), .o_so_oe(so_oe), .o_write_start(wstart), .o_wel(write_enable_latch), .o_busy(busy));
    sepc_host_model u_host (.i_core_clk(i_core_clk), .i_so(so), .i_so_oe(so_oe),
        .o_sck(sck), .o_cs_n(cs_n), .o_si(si), .o_hold_n(hold_n));

    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic send(input logic [7:0] op, input int extra);
        u_host.select();
        u_host.shift(8, op, rx);
        for (int i = 0; i < extra; i++) u_host.shift(8, 8'h5A, rx);
    endtask

    task automatic status(input logic [7:0] exp, input string what);
        send(OP_STAT_RD, 1);
        u_host.deselect();
        check(what, exp, rx);
    endtask

    task automatic t_power();
        check("wel", 8'h00, {7'h0, write_enable_latch});
        check("busy", 8'h00, {7'h0, busy});
        status(8'h00, "status after power-up");
        send(OP_WRITE, 3);
        u_host.deselect();
        check("start without latch", 8'h00, n_start[7:0]);
        $display("test power done");
    endtask

    task automatic t_write_enable_command_unknown();
        send(OP_WR_EN, 0);
        u_host.deselect();
        check("wel set", 8'h01, {7'h0, write_enable_latch});
        status(8'h02, "status latch");
        send(8'hFF, 1);
        u_host.deselect();
        check("unknown oe", 8'h00, {7'h0, u_host.oe_seen});
        check("unknown wel", 8'h01, {7'h0, write_enable_latch});
        $display("test latch done");
    endtask

    task automatic t_pause();
        u_host.select();
        u_host.shift(4, 8'h00, rx);
        u_host.pause(16, f1);
        u_host.shift(4, OP_STAT_RD, rx);
        u_host.shift(4, 8'h00, rx);
        u_host.pause(16, f2);
        u_host.shift(4, 8'h00, ry);
        u_host.deselect();
        check("paused oe", 8'h00, {6'h0, f1, f2});
        check("resumed status", 8'h02, {rx[3:0], ry[3:0]});
        $display("test pause done");
    endtask

    task automatic t_write();
        int cnt;
        send(OP_WRITE, 3);
        check("start before release", 8'h00, {busy, n_start[6:0]});
        u_host.deselect();
        check("start pulses", 8'h01, n_start[7:0]);
        status(8'h03, "status busy");
        send(OP_READ, 3);
        u_host.deselect();
        check("read while busy oe", 8'h00, {7'h0, u_host.oe_seen});
        send(OP_WR_DIS, 0);
        u_host.deselect();
        check("disable while busy", 8'h01, {7'h0, write_enable_latch});
        cnt = 0;
        while (busy === 1'b1 && cnt < 1100) begin
            @(negedge i_core_clk);
            cnt++;
        end
        check("wel after cycle", 8'h00, {7'h0, write_enable_latch});
        status(8'h00, "status idle");
        send(OP_READ, 3);
        u_host.deselect();
        check("read data", 8'hA5, rx);
        $display("test write done");
    endtask

    // Status write keeps only bits 7, 6, 4, 3 and 2 of the 5A data byte.
    task automatic t_stat_write();
        int cnt;
        send(OP_STAT_WR, 1);
        u_host.deselect();
        check("wrsr without latch", 8'h01, n_start[7:0]);
        send(OP_WR_EN, 0);
        u_host.deselect();
        send(OP_STAT_WR, 1);
        u_host.deselect();
        check("wrsr start", 8'h02, n_start[7:0]);
        status(8'h5B, "status during wrsr");
        cnt = 0;
        while (busy === 1'b1 && cnt < 1100) begin
            @(negedge i_core_clk);
            cnt++;
        end
        check("busy after wrsr", 8'h00, {7'h0, busy});
        status(8'h58, "status after wrsr");
        send(OP_WR_EN, 0);
        u_host.deselect();
        send(OP_WR_DIS, 0);
        u_host.deselect();
        check("wel after disable", 8'h00, {7'h0, write_enable_latch});
        send(OP_WRITE, 3);
        u_host.deselect();
        check("write after disable", 8'h02, n_start[7:0]);
        $display("test status write done");
    endtask

    task automatic t_brown();
        send(OP_WR_EN, 0);
        u_host.deselect();
        @(posedge i_core_clk);
        i_rst <= 1'b1;
        repeat (2) @(posedge i_core_clk);
        @(negedge i_core_clk);
        check("wel in reset", 8'h00, {6'h0, write_enable_latch, busy});
        @(posedge i_core_clk);
        i_rst <= 1'b0;
        repeat (3) @(posedge i_core_clk);
        status(8'h00, "status after brown-out");
        $display("test brown-out done");
    endtask

    task automatic complete_run();
        $display("checks_done %0d n_fail %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // Whole run needs about 5000 core cycles; the limit leaves ample slack.
    initial begin
        repeat (20000) @(posedge i_core_clk);
        n_fail++;
        complete_run();
    end

    initial begin
        repeat (12) @(posedge i_core_clk);
        i_rst <= 1'b0;
        repeat (3) @(posedge i_core_clk);
        @(negedge i_core_clk);
        t_power();
        t_write_enable_command_unknown();
        t_pause();
        t_write();
        t_stat_write();
        t_brown();
        complete_run();
    end
endmodule // tb_top
